/* File: logic/oisa_pkg.sv */
package oisa_pkg;

  // data and address widths
  localparam int OISA_DATA_W  = 8;
  localparam int OISA_ADDR_W  = 7;
  localparam int OISA_REG_NUM = 128;

  // reset values
  localparam logic [7:0] OISA_ACC_RST  = 8'h00;
  localparam logic       OISA_FLAG_RST = 1'b0;

  // target_select encoding
  localparam logic OISA_TGT_ACC = 1'b0;
  localparam logic OISA_TGT_REG = 1'b1;

  // operation codes
  typedef enum logic [2:0] {
    OISA_OP_NONE,
    OISA_OP_OR_IMM,
    OISA_OP_OR_REG,
    OISA_OP_INC_REG,
    OISA_OP_SHL,
    OISA_OP_SHR
  } oisa_op_e;

  // one issued operation
  typedef struct packed {
    oisa_op_e   op;
    logic [7:0] imm;
    logic [6:0] addr;
    logic       target;
  } oisa_cmd_s;

  // status flags
  typedef struct packed {
    logic null_flag;
    logic shift_out;
  } oisa_flags_s;

endpackage : oisa_pkg

/* File: logic/oisa_regfile.sv */
`timescale 1ns/1ps
// file registers: async read for the operand, one synchronous write port
module oisa_regfile
  import oisa_pkg::*;
#(
  parameter int DEPTH = OISA_REG_NUM,
  parameter int AW    = OISA_ADDR_W
)(
  input  wire logic          clk,     // core clock
  input  wire logic [AW-1:0] raddr,   // operand address
  output logic      [7:0]    rdata,   // operand value
  input  wire logic          we,      // write strobe
  input  wire logic [AW-1:0] waddr,   // write address
  input  wire logic [7:0]    wdata    // write value
);

  // storage; contents undefined until written, like real file memory
  logic [7:0] mem [DEPTH];

  // operand must be visible in the issue cycle, so the read is direct
  assign rdata = mem[raddr];

  // write port
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

endmodule : oisa_regfile

/* File: logic/oisa_alu.sv */
`timescale 1ns/1ps
// Behaviour
// - or immediate into accumulator
// - target_select zero accumulator, one register
// - increment adds one, routed by target
// - or accumulator with register, routed
// - left shift, bit7 out, zero in
// - left shift routed, carry and zero updated
// - right shift, zero in, bit0 out
// - right shift routed, carry and zero updated
module oisa_alu
  import oisa_pkg::*;
(
  input  wire logic        clk,       // core instruction clock
  input  wire logic        resetn,    // async reset, active low
  input  wire oisa_cmd_s   cmd,       // operation, valid for one cycle
  input  wire logic        cmd_valid, // operation issue strobe
  output logic      [7:0]  acc,       // accumulator
  output oisa_flags_s      flags,     // null and shift-out flags
  input  wire logic [6:0]  peek_addr, // debug read address
  output logic      [7:0]  peek_data  // debug read data (registered)
);

  // operand and datapath wires
  logic [7:0] operand;      // file register contents
  logic [7:0] result;       // computed 8-bit result
  logic       shift_bit;    // bit leaving a shift
  logic       is_shift;     // shift operations touch the carry
  logic       is_reg_op;    // operation addresses a file register
  logic       go;           // a real operation this cycle
  logic       to_reg;       // result goes back to the file register
  logic       to_acc;       // result goes to the accumulator
  logic [7:0] peek_raw;     // unregistered debug read

  logic [7:0]  acc_r;
  logic [7:0]  acc_nxt;
  oisa_flags_s flags_r;
  oisa_flags_s flags_nxt;
  logic [7:0]  peek_r;

  assign go        = cmd_valid && (cmd.op != OISA_OP_NONE);
  assign is_shift  = (cmd.op == OISA_OP_SHL) || (cmd.op == OISA_OP_SHR);
  assign is_reg_op = go && (cmd.op != OISA_OP_OR_IMM);

  // result selection per operation
  // or with immediate byte
  // register plus one, wraps at 8 bits
  // left shift inserts zero at bit 0
  // right shift inserts zero at bit 7
  assign result =
    (cmd.op == OISA_OP_OR_IMM)  ? (acc_r | cmd.imm) :
    (cmd.op == OISA_OP_OR_REG)  ? (acc_r | operand) :
    (cmd.op == OISA_OP_INC_REG) ? 8'(operand + 8'h01) :
    (cmd.op == OISA_OP_SHL)     ? {operand[6:0], 1'b0} :
    (cmd.op == OISA_OP_SHR)     ? {1'b0, operand[7:1]} :
                                  acc_r;

  // bit 7 leaves on a left shift
  // bit 0 leaves on a right shift
  assign shift_bit = (cmd.op == OISA_OP_SHL) ? operand[7] : operand[0];

  // destination decode
  // target 1 writes back except on the immediate op, 0 goes to accumulator
  // left shift honours the target too
  // right shift honours the target too
  assign to_reg = is_reg_op && (cmd.target == OISA_TGT_REG);
  assign to_acc = go && !to_reg;

  assign acc_nxt = to_acc ? result : acc_r;

  // zero flag from result, carry only on shifts
  assign flags_nxt.null_flag = go ? (result == 8'h00) : flags_r.null_flag;
  assign flags_nxt.shift_out = (go && is_shift) ? shift_bit
                                                : flags_r.shift_out;

  // file registers
  oisa_regfile u_regs (
    .clk   (clk),
    .raddr (cmd.addr),
    .rdata (operand),
    .we    (to_reg),
    .waddr (cmd.addr),
    .wdata (result)
  );

  // second read port for observation; a copy keeps one writer
  oisa_regfile u_shadow (
    .clk   (clk),
    .raddr (peek_addr),
    .rdata (peek_raw),
    .we    (to_reg),
    .waddr (cmd.addr),
    .wdata (result)
  );

  // accumulator and flags
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_r   <= OISA_ACC_RST;
      flags_r <= '{null_flag: OISA_FLAG_RST, shift_out: OISA_FLAG_RST};
    end
    else
    begin
      acc_r   <= acc_nxt;
      flags_r <= flags_nxt;
    end
  end

  // registered debug data
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      peek_r <= 8'h00;
    else
      peek_r <= peek_raw;
  end

  assign acc       = acc_r;
  assign flags     = flags_r;
  assign peek_data = peek_r;

  // checks
  a_or_imm_acc: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_OR_IMM
      |=> acc == ($past(acc) | $past(cmd.imm)))
    else $error("or immediate result wrong");

  a_target_reg_keeps: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op != OISA_OP_NONE && cmd.op != OISA_OP_OR_IMM
      && cmd.target == OISA_TGT_REG |=> $stable(acc))
    else $error("accumulator changed on register target");

  a_inc_acc: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_INC_REG && cmd.target == OISA_TGT_ACC
      |=> acc == 8'($past(operand) + 8'h01))
    else $error("increment result wrong");

  a_or_reg_acc: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_OR_REG && cmd.target == OISA_TGT_ACC
      |=> acc == ($past(acc) | $past(operand)))
    else $error("or register result wrong");

  a_shl_bits: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_SHL && cmd.target == OISA_TGT_ACC
      |=> acc[0] == 1'b0 && acc[7:1] == $past(operand[6:0]))
    else $error("left shift bits wrong");

  a_shl_flags: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_SHL
      |=> flags.shift_out == $past(operand[7])
          && flags.null_flag == ($past(operand[6:0]) == 7'h00))
    else $error("left shift flags wrong");

  a_shr_bits: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_SHR && cmd.target == OISA_TGT_ACC
      |=> acc[7] == 1'b0 && acc[6:0] == $past(operand[7:1]))
    else $error("right shift bits wrong");

  a_shr_flags: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_SHR
      |=> flags.shift_out == $past(operand[0])
          && flags.null_flag == ($past(operand[7:1]) == 7'h00))
    else $error("right shift flags wrong");

  a_carry_kept: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && (cmd.op == OISA_OP_OR_IMM || cmd.op == OISA_OP_OR_REG
      || cmd.op == OISA_OP_INC_REG) |=> $stable(flags.shift_out))
    else $error("carry changed by or/increment");

  // zero flag tracks accumulator
  // only where the result lands in the accumulator can the flag be
  // judged from an output; register targets are covered by the bench
  a_null_on_acc: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op != OISA_OP_NONE
      && (cmd.op == OISA_OP_OR_IMM || cmd.target == OISA_TGT_ACC)
      |=> flags.null_flag == (acc == 8'h00))
    else $error("zero flag disagrees with accumulator");

  // increment wraps to zero
  // the top value must roll over and raise the zero flag together
  a_inc_wrap: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_INC_REG && operand == 8'hff
      |=> flags.null_flag)
    else $error("increment wrap did not flag zero");

  // idle cycles change nothing
  // a dropped strobe or the empty op must leave acc and flags alone
  a_idle_holds: assert property (@(posedge clk) disable iff (!resetn)
    !cmd_valid || cmd.op == OISA_OP_NONE
      |=> $stable(acc) && $stable(flags))
    else $error("state changed without an operation");

  // immediate op ignores target
  // the immediate op has no file operand, so target must not matter
  a_imm_to_acc: assert property (@(posedge clk) disable iff (!resetn)
    cmd_valid && cmd.op == OISA_OP_OR_IMM && cmd.target == OISA_TGT_REG
      |=> acc == ($past(acc) | $past(cmd.imm)))
    else $error("immediate op honoured register target");

endmodule : oisa_alu

/* File: verification/tb_oisa_alu.sv */
`timescale 1ns/1ps
module tb_oisa_alu
  import oisa_pkg::*;
;
  logic        clk        = 1'b0;  // core clock
  logic        resetn     = 1'b0;  // reset, active low
  oisa_cmd_s   cmd        = '0;    // issued operation
  logic        cmd_valid  = 1'b0;  // issue strobe
  logic [6:0]  peek_addr  = 7'h00; // observation address
  logic [7:0]  acc;                // accumulator
  oisa_flags_s flags;              // {null_flag, shift_out}
  logic [7:0]  peek_data;          // observed file register
  int          bad_count  = 0;     // mismatches
  int          n_compared = 0;     // comparisons made

  // 25 MHz clock
  always #20 clk = ~clk;

  oisa_alu uut (
    .clk       (clk),
    .resetn    (resetn),
    .cmd       (cmd),
    .cmd_valid (cmd_valid),
    .acc       (acc),
    .flags     (flags),
    .peek_addr (peek_addr),
    .peek_data (peek_data)
  );

  // four-state compare, counts every call
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("mismatches %0d, compared %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // one operation; returns 1 ns after the edge that takes it
  task automatic issue(input oisa_op_e o, input logic [7:0] k,
                       input logic [6:0] a, input logic t);
    @(posedge clk);
    #1;
    cmd       = '{op: o, imm: k, addr: a, target: t};
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
  endtask : issue

  // peek_data is registered, so wait one edge after the address
  task automatic peek(input logic [6:0] a);
    peek_addr = a;
    @(posedge clk);
    #1;
  endtask : peek

  // file registers have no reset: force ff, wrap to 00, then or in v
  task automatic load(input logic [6:0] a, input logic [7:0] v);
    issue(OISA_OP_OR_IMM, 8'hff, 7'h00, OISA_TGT_ACC);
    issue(OISA_OP_OR_REG, 8'h00, a, OISA_TGT_REG);
    issue(OISA_OP_INC_REG, 8'h00, a, OISA_TGT_REG);
    issue(OISA_OP_SHL, 8'h00, a, OISA_TGT_ACC);
    issue(OISA_OP_OR_IMM, v, 7'h00, OISA_TGT_ACC);
    issue(OISA_OP_OR_REG, 8'h00, a, OISA_TGT_REG);
  endtask : load

  // or paths, top address, idle op ignored
  task automatic t_or;
    load(7'h7f, 8'h50);
    chk(acc, 8'h50);
    peek(7'h7f);
    chk(peek_data, 8'h50);
    issue(OISA_OP_OR_IMM, 8'h0a, 7'h7f, OISA_TGT_REG);
    chk(acc, 8'h5a);
    chk({6'h00, flags}, 8'h00);
    issue(OISA_OP_NONE, 8'hff, 7'h7f, OISA_TGT_ACC);
    chk(acc, 8'h5a);
  endtask : t_or

  // left shift to acc sets carry, increment wraps and keeps it
  task automatic t_inc;
    load(7'h00, 8'hff);
    issue(OISA_OP_SHL, 8'h00, 7'h00, OISA_TGT_ACC);
    chk(acc, 8'hfe);
    chk({6'h00, flags}, 8'h01);
    issue(OISA_OP_INC_REG, 8'h00, 7'h00, OISA_TGT_ACC);
    chk(acc, 8'h00);
    chk({6'h00, flags}, 8'h03);
    peek(7'h00);
    chk(peek_data, 8'hff);
  endtask : t_inc

  // shifts and increment written back, acc left alone
  task automatic t_shift;
    load(7'h11, 8'h01);
    issue(OISA_OP_SHR, 8'h00, 7'h11, OISA_TGT_REG);
    chk({6'h00, flags}, 8'h03);
    chk(acc, 8'h01);
    peek(7'h11);
    chk(peek_data, 8'h00);
    load(7'h22, 8'h81);
    issue(OISA_OP_SHL, 8'h00, 7'h22, OISA_TGT_REG);
    chk({6'h00, flags}, 8'h01);
    issue(OISA_OP_INC_REG, 8'h00, 7'h22, OISA_TGT_REG);
    chk(acc, 8'h81);
    peek(7'h22);
    chk(peek_data, 8'h03);
  endtask : t_shift

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    chk(acc, OISA_ACC_RST);
    resetn = 1'b1;
    t_or();
    t_inc();
    t_shift();
    end_sim();
  end

  // watchdog: the run needs under 3 us
  initial
  begin
    #20000;
    bad_count++;
    end_sim();
  end
endmodule : tb_oisa_alu
